//--- src/drive_cmd_pkg.sv
package drive_cmd_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets on the bus
   localparam logic [4:0] CFG_OFS = 5'h00;
   localparam logic [4:0] TERM_ASSIGN_A_OFS = 5'h04;
   localparam logic [4:0] TERM_ASSIGN_B_OFS = 5'h08;
   localparam logic [4:0] OUT_ASSIGN_OFS = 5'h0C;
   localparam logic [4:0] STATUS_OFS = 5'h10;
   localparam logic [4:0] IRQ_STATUS_OFS = 5'h14;
   localparam logic [4:0] IRQ_MASK_OFS = 5'h18;
   localparam logic [4:0] CONTROL_OFS = 5'h1C;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [31:0] CFG_RST = 32'h0000_0000;
   localparam logic [31:0] TERM_ASSIGN_A_RST = 32'h0000_0000;
   // Run terminal 1 forward, run terminal 2 reverse
   localparam logic [31:0] TERM_ASSIGN_B_RST = 32'h0063_6200;
   localparam logic [31:0] OUT_ASSIGN_RST = 32'h0000_0000;
   localparam logic [2:0] IRQ_MASK_RST = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Configuration field positions
   localparam int CFG_POL_BIT = 0;
   localparam int CFG_PID_MODE_LSB = 1;
   localparam int CFG_ANALOG_SRC_BIT = 3;
   localparam int CFG_DECEL_LSB = 16;
   localparam int OUT_POL_BIT = 7;
   localparam int CTRL_ALARM_CLR_BIT = 0;

   // PID mode encodings
   localparam logic [1:0] PID_MODE_OFF = 2'h0;
   localparam logic [1:0] PID_MODE_NORMAL = 2'h1;
   localparam logic [1:0] PID_MODE_INVERSE = 2'h2;

   // Interrupt bit positions
   localparam int IRQ_ALARM_BIT = 0;
   localparam int IRQ_MONITOR_BIT = 1;
   localparam int IRQ_RUN_START_BIT = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Terminal function codes
   localparam int N_GEN_TERM = 5;
   localparam int N_ALL_TERM = 7;
   localparam int N_FUNC = 10;
   localparam logic [7:0] FN_PID_BYPASS = 8'h14;
   localparam logic [7:0] FN_MONITOR = 8'h19;
   localparam logic [7:0] FN_FWD = 8'h62;
   localparam logic [7:0] FN_REV = 8'h63;
   localparam logic [7:0] ALARM_SIG_CODE = 8'h63;
   // Index order: bypass, invert, link, monitor, search, feedback,
   // forced stop, accum reset, integral hold, overload stop
   localparam logic [7:0] FUNC_CODES [N_FUNC] = '{
      8'h14, 8'h15, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1E, 8'h21, 8'h22, 8'h2E};

endpackage

//--- src/terminal_function_match.sv
`timescale 1ns/100ps
// Finds the terminals assigned to one function code
module terminal_function_match #(
   parameter int N = 7
) (
   input wire logic [N*8-1:0] i_codes,
   input wire logic [N-1:0] i_terms,
   input wire logic [7:0] i_code,
   output logic o_on,
   output logic o_assigned
);

   // Any assigned terminal that is high turns the function on
   always_comb begin
      o_on = 1'b0;
      o_assigned = 1'b0;
      for (int k = 0; k < N; k++) begin
         if (i_codes[k*8 +: 8] == i_code) begin
            o_assigned = 1'b1;
            o_on = o_on | i_terms[k];
         end
      end
   end

endmodule

//--- src/output_terminal_select.sv
`timescale 1ns/100ps
// One programmable output terminal: signal pick plus polarity
module output_terminal_select (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [127:0] i_signals,
   input wire logic [7:0] i_assign,
   output logic o_level
);

   // Registered so the pin never glitches on a reassignment
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_level <= 1'b0;
      end else begin
         o_level <= i_signals[i_assign[6:0]] ^ i_assign[drive_cmd_pkg::OUT_POL_BIT];
      end
   end

endmodule

//--- src/drive_terminal_command_decoder.sv
`timescale 1ns/100ps
// How it works
// - Invert only analog sources of primary command
// - Analog direction: polarity setting XOR invert
// - Bypass ON disables PID, uses manual frequency
// - PID polarity from mode, invert flips it
// - PID mode not off: manual polarity from setting only
// - Link priority command; unassigned means ON
// - Monitor-only inputs reported, no drive effect
// - Speed search command sampled at run start
// - Feedback enable changes only while stopped
// - Forced stop decelerates, then enters alarm
// - Reset command clears integral and derivative
// - Hold command freezes the integral term
// - Overload stop enable; unassigned means enabled
// - Forward run, only from run terminals
// - Reverse run, only from run terminals
// - Output terminals select signal and polarity
// - Relay energises on its selected signal (alarm is code 63h), negative inverts
module drive_terminal_command_decoder (
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Avalon-MM slave
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Terminal inputs
   input wire logic [4:0] i_gen_terms,
   input wire logic [1:0] i_run_terms,
   input wire logic i_motor_running,
   input wire logic [127:0] i_drive_signals,
   // Decoded commands
   output logic o_analog_dir_invert,
   output logic o_pid_enable,
   output logic o_pid_out_invert,
   output logic o_manual_freq_invert,
   output logic o_link_priority,
   output logic o_speed_search_en,
   output logic o_speed_feedback_en,
   output logic o_forced_stop_req,
   output logic [15:0] o_forced_stop_decel_time,
   output logic o_alarm,
   output logic o_pid_accum_reset,
   output logic o_pid_integral_hold,
   output logic o_overload_stop_en,
   output logic o_run_forward,
   output logic o_run_reverse,
   output logic o_out_y1,
   output logic o_out_y2,
   output logic o_relay_energize,
   output logic o_irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [31:0] cfg_q; // Polarity, PID mode, source, decel time
   logic [31:0] assign_a_q; // Codes of general terminals 0..3
   logic [31:0] assign_b_q; // Terminal 4 and both run terminals
   logic [23:0] out_assign_q; // Y1, Y2, relay assignments
   logic [2:0] irq_status_q; // Sticky events
   logic [2:0] irq_mask_q; // Interrupt enables
   logic ack_q; // Bus answer cycle
   logic [31:0] rdata_q; // Captured read word

   // Internal state
   logic alarm_q; // Forced stop alarm
   logic run_q; // Run command last cycle
   logic [4:0] mon_q; // Monitor inputs last cycle
   logic search_q; // Latched speed search choice
   logic feedback_q; // Latched feedback enable

   // Decode results
   localparam int N_ALL_TERM_W = drive_cmd_pkg::N_ALL_TERM * 8;
   logic [N_ALL_TERM_W-1:0] all_codes;
   logic [drive_cmd_pkg::N_ALL_TERM-1:0] all_terms;
   logic [drive_cmd_pkg::N_FUNC-1:0] fn_on; // Function active
   logic [drive_cmd_pkg::N_FUNC-1:0] fn_asg; // Function assigned
   logic fwd_on; // Forward from run terminals
   logic rev_on; // Reverse from run terminals
   logic [4:0] mon_in; // Monitor-only terminal levels
   logic [1:0] pid_mode;
   logic polarity;
   logic invert_cmd;
   logic pid_on;
   logic stop_req;
   logic run_cmd;
   logic run_start;
   logic alarm_set;
   logic mon_change;
   logic [2:0] irq_events;
   logic [127:0] signals;

   // Bus strobes
   logic req;
   logic wr_en;
   logic [31:0] bmask; // Byte enables as a bit mask

   ////////////////////////////////////////////////////////////////////////////
   // Terminal decoding
   assign all_codes = {assign_b_q[23:0], assign_a_q};
   assign all_terms = {i_run_terms, i_gen_terms};

   // One matcher per general function, over all terminals
   for (genvar f = 0; f < drive_cmd_pkg::N_FUNC; f++) begin : g_fn
      terminal_function_match #(
         .N(drive_cmd_pkg::N_ALL_TERM)
      ) u_match (
         .i_codes(all_codes),
         .i_terms(all_terms),
         .i_code(drive_cmd_pkg::FUNC_CODES[f]),
         .o_on(fn_on[f]),
         .o_assigned(fn_asg[f])
      );
   end

   // Run commands only from the two run terminals
   terminal_function_match #(
      .N(2)
   ) u_fwd (
      .i_codes(assign_b_q[23:8]),
      .i_terms(i_run_terms),
      .i_code(drive_cmd_pkg::FN_FWD),
      .o_on(fwd_on),
      .o_assigned()
   );

   terminal_function_match #(
      .N(2)
   ) u_rev (
      .i_codes(assign_b_q[23:8]),
      .i_terms(i_run_terms),
      .i_code(drive_cmd_pkg::FN_REV),
      .o_on(rev_on),
      .o_assigned()
   );

   // Monitor-only terminals, fed to status and the monitor interrupt only
   always_comb begin
      for (int k = 0; k < 5; k++) begin
         mon_in[k] = i_gen_terms[k] & (all_codes[k*8 +: 8] == drive_cmd_pkg::FN_MONITOR);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command conditions
   assign pid_mode = cfg_q[drive_cmd_pkg::CFG_PID_MODE_LSB +: 2];
   assign polarity = cfg_q[drive_cmd_pkg::CFG_POL_BIT];
   assign invert_cmd = fn_on[1];
   // PID runs only in a process mode with bypass off
   assign pid_on = ((pid_mode == drive_cmd_pkg::PID_MODE_NORMAL) ||
                    (pid_mode == drive_cmd_pkg::PID_MODE_INVERSE)) && !fn_on[0];
   // Forced stop only when assigned and the terminal is low
   assign stop_req = fn_asg[6] && !fn_on[6];
   // Both directions at once counts as no run
   assign run_cmd = fwd_on ^ rev_on;
   assign run_start = run_cmd && !run_q && !i_motor_running;
   assign alarm_set = stop_req && !i_motor_running && !alarm_q;
   assign mon_change = (mon_in != mon_q);
   assign irq_events = {run_start, mon_change, alarm_set};

   // Alarm signal merged into the output signal vector
   always_comb begin
      signals = i_drive_signals;
      signals[drive_cmd_pkg::ALARM_SIG_CODE[6:0]] =
         i_drive_signals[drive_cmd_pkg::ALARM_SIG_CODE[6:0]] | alarm_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshake: one wait cycle, answer on the second
   assign req = (i_avs_read || i_avs_write) && !ack_q;
   assign wr_en = i_avs_write && !ack_q;
   assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;
   assign o_avs_readdata = rdata_q;

   // Byte enables to bit mask
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         bmask[b*8 +: 8] = {8{i_avs_byteenable[b]}};
      end
   end

   // Answer strobe
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req;
      end
   end

   // Read word capture, unmapped reads as zero
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_q <= 32'h0000_0000;
      end else if (req && i_avs_read) begin
         case (i_avs_address)
            drive_cmd_pkg::CFG_OFS: rdata_q <= cfg_q;
            drive_cmd_pkg::TERM_ASSIGN_A_OFS: rdata_q <= assign_a_q;
            drive_cmd_pkg::TERM_ASSIGN_B_OFS: rdata_q <= assign_b_q;
            drive_cmd_pkg::OUT_ASSIGN_OFS: rdata_q <= {8'h00, out_assign_q};
            drive_cmd_pkg::STATUS_OFS: begin
               rdata_q <= {17'h0_0000, o_run_reverse, o_run_forward, pid_on,
                           feedback_q, search_q, stop_req, alarm_q,
                           3'h0, mon_in};
            end
            drive_cmd_pkg::IRQ_STATUS_OFS: rdata_q <= {29'h0000_0000, irq_status_q};
            drive_cmd_pkg::IRQ_MASK_OFS: rdata_q <= {29'h0000_0000, irq_mask_q};
            default: rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // Configuration and assignment registers
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg_q <= drive_cmd_pkg::CFG_RST;
         assign_a_q <= drive_cmd_pkg::TERM_ASSIGN_A_RST;
         assign_b_q <= drive_cmd_pkg::TERM_ASSIGN_B_RST;
         out_assign_q <= drive_cmd_pkg::OUT_ASSIGN_RST[23:0];
         irq_mask_q <= drive_cmd_pkg::IRQ_MASK_RST;
      end else if (wr_en) begin
         case (i_avs_address)
            drive_cmd_pkg::CFG_OFS: begin
               cfg_q <= (cfg_q & ~bmask) | (i_avs_writedata & bmask);
            end
            drive_cmd_pkg::TERM_ASSIGN_A_OFS: begin
               assign_a_q <= (assign_a_q & ~bmask) | (i_avs_writedata & bmask);
            end
            drive_cmd_pkg::TERM_ASSIGN_B_OFS: begin
               assign_b_q <= (assign_b_q & ~bmask) | (i_avs_writedata & bmask);
            end
            drive_cmd_pkg::OUT_ASSIGN_OFS: begin
               out_assign_q <= (out_assign_q & ~bmask[23:0]) |
                               (i_avs_writedata[23:0] & bmask[23:0]);
            end
            drive_cmd_pkg::IRQ_MASK_OFS: begin
               if (i_avs_byteenable[0]) begin
                  irq_mask_q <= i_avs_writedata[2:0];
               end
            end
            default: begin
               // Read-only, unmapped, or written in another block: ignored
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status: write one to clear, a new event wins
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_status_q <= 3'h0;
      end else begin
         if (wr_en && (i_avs_address == drive_cmd_pkg::IRQ_STATUS_OFS) &&
             i_avs_byteenable[0]) begin
            irq_status_q <= (irq_status_q & ~i_avs_writedata[2:0]) | irq_events;
         end else begin
            irq_status_q <= irq_status_q | irq_events;
         end
      end
   end

   // Level interrupt from unmasked sticky bits
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(irq_status_q & irq_mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Forced stop alarm, cleared from control, a new stop wins
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         alarm_q <= 1'b0;
      end else if (alarm_set) begin
         alarm_q <= 1'b1;
      end else if (wr_en && (i_avs_address == drive_cmd_pkg::CONTROL_OFS) &&
                   i_avs_byteenable[0] &&
                   i_avs_writedata[drive_cmd_pkg::CTRL_ALARM_CLR_BIT]) begin
         alarm_q <= stop_req && !i_motor_running;
      end
   end

   // Run edge and monitor history
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         run_q <= 1'b0;
         mon_q <= 5'h00;
      end else begin
         run_q <= run_cmd;
         mon_q <= mon_in;
      end
   end

   // Speed search choice caught at the start of a run
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         search_q <= 1'b0;
      end else if (run_start) begin
         search_q <= fn_on[4];
      end
   end

   // Feedback enable follows the terminal only while stopped
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         feedback_q <= 1'b1;
      end else if (!i_motor_running) begin
         feedback_q <= fn_on[5] || !fn_asg[5];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered command outputs
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_analog_dir_invert <= 1'b0;
         o_pid_enable <= 1'b0;
         o_pid_out_invert <= 1'b0;
         o_manual_freq_invert <= 1'b0;
         o_link_priority <= 1'b1;
         o_pid_accum_reset <= 1'b0;
         o_pid_integral_hold <= 1'b0;
         o_overload_stop_en <= 1'b1;
         o_run_forward <= 1'b0;
         o_run_reverse <= 1'b0;
      end else begin
         // Only an analog primary source is switched
         o_analog_dir_invert <= cfg_q[drive_cmd_pkg::CFG_ANALOG_SRC_BIT] &&
                                (polarity ^ invert_cmd);
         o_pid_enable <= pid_on;
         o_pid_out_invert <= pid_on &&
                             ((pid_mode == drive_cmd_pkg::PID_MODE_INVERSE) ^
                              invert_cmd);
         // Manual path ignores the invert command in process mode
         if (pid_mode != drive_cmd_pkg::PID_MODE_OFF) begin
            o_manual_freq_invert <= polarity;
         end else begin
            o_manual_freq_invert <= cfg_q[drive_cmd_pkg::CFG_ANALOG_SRC_BIT] &&
                                    (polarity ^ invert_cmd);
         end
         o_link_priority <= fn_on[2] || !fn_asg[2];
         o_pid_accum_reset <= fn_on[7];
         o_pid_integral_hold <= fn_on[8];
         o_overload_stop_en <= fn_on[9] || !fn_asg[9];
         // No run while forced stop or alarm holds
         o_run_forward <= fwd_on && !rev_on && !stop_req && !alarm_q;
         o_run_reverse <= rev_on && !fwd_on && !stop_req && !alarm_q;
      end
   end

   // Direct state outputs
   assign o_speed_search_en = search_q;
   assign o_speed_feedback_en = feedback_q;
   assign o_forced_stop_req = stop_req;
   assign o_forced_stop_decel_time = cfg_q[drive_cmd_pkg::CFG_DECEL_LSB +: 16];
   assign o_alarm = alarm_q;

   ////////////////////////////////////////////////////////////////////////////
   // Programmable output terminals
   output_terminal_select u_y1 (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_signals(signals),
      .i_assign(out_assign_q[7:0]),
      .o_level(o_out_y1)
   );

   output_terminal_select u_y2 (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_signals(signals),
      .i_assign(out_assign_q[15:8]),
      .o_level(o_out_y2)
   );

   output_terminal_select u_relay (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_signals(signals),
      .i_assign(out_assign_q[23:16]),
      .o_level(o_relay_energize)
   );

endmodule

//--- verification/term_ctrl_model.sv
`timescale 1ns/100ps
// Far-side controller: drives terminal levels on a clock edge
module term_ctrl_model (
   input wire logic i_clk,
   input wire logic [4:0] i_gen_set,
   input wire logic [1:0] i_run_set,
   input wire logic i_running_set,
   output logic [4:0] o_gen_terms,
   output logic [1:0] o_run_terms,
   output logic o_motor_running
);
   //////////////////////////////////////////////////////////////////////////
   // Levels change only just after an edge
   always_ff @(posedge i_clk) begin
      o_gen_terms <= i_gen_set;
      o_run_terms <= i_run_set;
      o_motor_running <= i_running_set;
   end
endmodule

//--- verification/decoder_chk.sv
`timescale 1ns/100ps
// Port-level relations of the command decoder
module decoder_chk (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic o_avs_waitrequest,
   input wire logic [1:0] i_run_terms,
   input wire logic i_motor_running,
   input wire logic o_pid_enable,
   input wire logic o_pid_out_invert,
   input wire logic o_speed_search_en,
   input wire logic o_speed_feedback_en,
   input wire logic o_forced_stop_req,
   input wire logic o_alarm,
   input wire logic o_run_forward,
   input wire logic o_run_reverse
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   //////////////////////////////////////////////////////////////////////////
   // Bus: one wait cycle, none while idle
   a_one_wait: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> !o_avs_waitrequest) else $error("wait not one cycle");
   a_idle_nowait: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
      else $error("wait while idle");
   // Run directions
   a_run_excl: assert property (!(o_run_forward && o_run_reverse))
      else $error("both run directions");
   a_run_cause: assert property ($rose(o_run_forward) || $rose(o_run_reverse)
      |-> $past(i_run_terms) != 2'b00) else $error("run without run terminal");
   // PID polarity only with PID on
   a_pid_pol: assert property (o_pid_out_invert |-> o_pid_enable)
      else $error("pid polarity while bypassed");
   // Feedback and search frozen while running
   a_fb_frozen: assert property ($past(i_motor_running) |-> $stable(o_speed_feedback_en))
      else $error("feedback changed while running");
   a_search_frozen: assert property ($past(i_motor_running) |-> $stable(o_speed_search_en))
      else $error("search changed while running");
   // Forced stop sequence
   a_alarm_cause: assert property ($rose(o_alarm)
      |-> $past(o_forced_stop_req) && !$past(i_motor_running)) else $error("alarm without stop");
   a_stop_blocks: assert property (o_forced_stop_req |=> !o_run_forward && !o_run_reverse)
      else $error("run during forced stop");
endmodule

bind drive_terminal_command_decoder decoder_chk decoder_chk_inst (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .o_avs_waitrequest(o_avs_waitrequest), .i_run_terms(i_run_terms),
   .i_motor_running(i_motor_running), .o_pid_enable(o_pid_enable),
   .o_pid_out_invert(o_pid_out_invert), .o_speed_search_en(o_speed_search_en),
   .o_speed_feedback_en(o_speed_feedback_en), .o_forced_stop_req(o_forced_stop_req),
   .o_alarm(o_alarm), .o_run_forward(o_run_forward), .o_run_reverse(o_run_reverse));

//--- verification/tb_drive_terminal_command_decoder.sv
`timescale 1ns/100ps
// Self-checking bench for the command decoder
module tb_drive_terminal_command_decoder;
   logic clk, rst_n, rd, wr, wait_req, running, running_set;
   logic [4:0] adr, gen, gen_set;
   logic [31:0] wdata, rdata, q;
   logic [1:0] run, run_set;
   logic [127:0] sigs;
   logic [17:0] o; // Decoded command outputs
   logic [15:0] decel;
   int err_total, samples_checked;
   //////////////////////////////////////////////////////////////////////////
   // Clock, watchdog
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      final_report();
   end
   //////////////////////////////////////////////////////////////////////////
   // Partner and design
   term_ctrl_model term_ctrl_model_inst (.i_clk(clk), .i_gen_set(gen_set),
      .i_run_set(run_set), .i_running_set(running_set), .o_gen_terms(gen),
      .o_run_terms(run), .o_motor_running(running));
   drive_terminal_command_decoder drive_terminal_command_decoder_inst (
      .i_clk(clk), .i_rst_n(rst_n), .i_avs_address(adr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .i_gen_terms(gen),
      .i_run_terms(run), .i_motor_running(running), .i_drive_signals(sigs),
      .o_analog_dir_invert(o[0]), .o_pid_enable(o[1]), .o_pid_out_invert(o[2]),
      .o_manual_freq_invert(o[3]), .o_link_priority(o[4]), .o_speed_search_en(o[5]),
      .o_speed_feedback_en(o[6]), .o_forced_stop_req(o[7]),
      .o_forced_stop_decel_time(decel), .o_alarm(o[8]), .o_pid_accum_reset(o[9]),
      .o_pid_integral_hold(o[10]), .o_overload_stop_en(o[11]), .o_run_forward(o[12]),
      .o_run_reverse(o[13]), .o_out_y1(o[14]), .o_out_y2(o[15]),
      .o_relay_energize(o[16]), .o_irq(o[17]));
   //////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      adr <= a;
      wdata <= d;
      rd <= !w;
      wr <= w;
      // Hold until waitrequest sampled low
      do begin
         @(posedge clk);
         n++;
      end while (wait_req !== 1'b0 && n < 50);
      if (n >= 50) chk(32'h0000_0001, 32'h0000_0000);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(q, exp);
   endtask
   // Terminal levels then settle
   task automatic terms(input logic [4:0] g, input logic [1:0] r, input logic m);
      @(posedge clk);
      gen_set <= g;
      run_set <= r;
      running_set <= m;
      repeat (4) @(posedge clk);
      #1;
   endtask
   //////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset;
      chk(o[11:4] & 8'h85, 8'h85);
      chk(o[11], 1'b1);
      rchk(drive_cmd_pkg::TERM_ASSIGN_B_OFS, drive_cmd_pkg::TERM_ASSIGN_B_RST);
      rchk(drive_cmd_pkg::CFG_OFS, 32'h0000_0000);
      rchk(5'h1E, 32'h0000_0000);
      bus(1'b1, drive_cmd_pkg::STATUS_OFS, 32'hFFFF_FFFF);
      rchk(drive_cmd_pkg::STATUS_OFS, 32'h0000_0800);
      $display("test reset done");
   endtask
   task automatic t_analog;
      bus(1'b1, drive_cmd_pkg::TERM_ASSIGN_A_OFS, 32'h0000_0015);
      for (int p = 0; p < 4; p++) begin
         bus(1'b1, drive_cmd_pkg::CFG_OFS, 32'h0000_0008 | 32'(p[0]));
         terms({4'h0, p[1]}, 2'b00, 1'b0);
         chk(o[0], p[0] ^ p[1]);
         chk(o[3], p[0] ^ p[1]);
      end
      bus(1'b1, drive_cmd_pkg::CFG_OFS, 32'h0000_0001);
      terms(5'h01, 2'b00, 1'b0);
      chk(o[0], 1'b0);
      $display("test analog done");
   endtask
   task automatic t_pid;
      bus(1'b1, drive_cmd_pkg::TERM_ASSIGN_A_OFS, 32'h0000_1415);
      for (int k = 0; k < 8; k++) begin
         bus(1'b1, drive_cmd_pkg::CFG_OFS, 32'h0000_0009 | 32'((k[2] + 1) << 1));
         terms({3'h0, k[1], k[0]}, 2'b00, 1'b0);
         chk(o[1], !k[1]);
         chk(o[2], !k[1] && (k[2] ^ k[0]));
         chk(o[3], 1'b1);
      end
      $display("test pid done");
   endtask
   task automatic t_flags;
      bus(1'b1, drive_cmd_pkg::TERM_ASSIGN_A_OFS, 32'h2E18_2221);
      bus(1'b1, drive_cmd_pkg::TERM_ASSIGN_B_OFS, 32'h0063_621B);
      terms(5'h00, 2'b00, 1'b1);
      chk({o[11], o[10], o[9], o[4], o[6]}, 5'h00);
      terms(5'h1F, 2'b00, 1'b1);
      chk({o[11], o[10], o[9], o[4], o[6]}, 5'h1E);
      terms(5'h1F, 2'b00, 1'b0);
      chk(o[6], 1'b1);
      $display("test flags done");
   endtask
   task automatic t_run;
      bus(1'b1, drive_cmd_pkg::TERM_ASSIGN_A_OFS, 32'h0000_001A);
      bus(1'b1, drive_cmd_pkg::TERM_ASSIGN_B_OFS, drive_cmd_pkg::TERM_ASSIGN_B_RST);
      bus(1'b1, drive_cmd_pkg::IRQ_MASK_OFS, 32'h0000_0004);
      terms(5'h01, 2'b01, 1'b0);
      chk({o[17], o[13:12], o[5]}, 4'hB);
      terms(5'h00, 2'b01, 1'b1);
      chk(o[5], 1'b1);
      bus(1'b1, drive_cmd_pkg::IRQ_STATUS_OFS, 32'h0000_0004);
      terms(5'h00, 2'b11, 1'b0);
      chk({o[17], o[13:12]}, 3'h0);
      terms(5'h00, 2'b10, 1'b0);
      chk({o[13:12], o[5]}, 3'h4);
      bus(1'b1, drive_cmd_pkg::IRQ_MASK_OFS, 32'h0000_0000);
      $display("test run done");
   endtask
   task automatic t_stop;
      sigs[5] <= 1'b1;
      terms(5'h10, 2'b00, 1'b0);
      bus(1'b1, drive_cmd_pkg::TERM_ASSIGN_B_OFS, 32'h0063_621E);
      bus(1'b1, drive_cmd_pkg::CFG_OFS, 32'h1234_0000);
      bus(1'b1, drive_cmd_pkg::OUT_ASSIGN_OFS, 32'h0063_8505);
      bus(1'b1, drive_cmd_pkg::IRQ_MASK_OFS, 32'h0000_0001);
      terms(5'h10, 2'b01, 1'b1);
      chk({o[16:12], o[8:7]}, 7'h14);
      chk(decel, 16'h1234);
      terms(5'h00, 2'b01, 1'b1);
      chk({o[12], o[8:7]}, 3'h1);
      terms(5'h00, 2'b01, 1'b0);
      chk({o[17:16], o[8]}, 3'h7);
      terms(5'h10, 2'b00, 1'b0);
      bus(1'b1, drive_cmd_pkg::CONTROL_OFS, 32'h0000_0001);
      bus(1'b1, drive_cmd_pkg::IRQ_STATUS_OFS, 32'h0000_0001);
      terms(5'h10, 2'b00, 1'b0);
      chk({o[17:16], o[8]}, 3'h0);
      bus(1'b1, drive_cmd_pkg::OUT_ASSIGN_OFS, 32'h00E3_8505);
      terms(5'h10, 2'b00, 1'b0);
      chk(o[16], 1'b1);
      bus(1'b1, drive_cmd_pkg::TERM_ASSIGN_A_OFS, 32'h0000_0019);
      terms(5'h11, 2'b00, 1'b0);
      bus(1'b0, drive_cmd_pkg::STATUS_OFS, 32'h0000_0000);
      chk(q & 32'h0000_001F, 32'h0000_0001);
      $display("test stop done");
   endtask
   //////////////////////////////////////////////////////////////////////////
   // Verdict
   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      err_total = 0;
      samples_checked = 0;
      rst_n = 1'b0;
      {rd, wr, running_set} = 3'h0;
      adr = 5'h00;
      wdata = 32'h0000_0000;
      gen_set = 5'h00;
      run_set = 2'b00;
      sigs = '0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      t_reset();
      t_analog();
      t_pid();
      t_flags();
      t_run();
      t_stop();
      final_report();
   end
endmodule
